// *** hdl/rwt_tracker.sv ***
// per-subscriber tracker of a reliable stateful writer
//
// Added by the designer: the register offsets and the plain strobed port.
module rwt_tracker import rwt_pkg::*; #(
  parameter int DEPTH = 8,
  parameter int REPAIR_CYC = REPAIR_CYCLES,
  // arbitrary writer identifier value
  parameter logic [31:0] WRITER_ID = 32'h0000_0A01
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic chgAdd,
  input wire logic [SEQ_W-1:0] chgAddSeq,
  input wire logic chgAddReject,
  output logic storeFull,
  input wire logic chgRemove,
  input wire logic [SEQ_W-1:0] chgRemoveSeq,
  input wire logic ackValid,
  input wire logic [SEQ_W-1:0] ackBase,
  input wire logic [DEPTH-1:0] ackBitmap,
  output logic txValid,
  input wire logic txReady,
  output rwt_kind_t txKind,
  output logic [SEQ_W-1:0] txSeq,
  output logic [SEQ_W-1:0] txSeqLast,
  output logic [31:0] txReaderId,
  output logic [31:0] txWriterId,
  output logic txInline,
  output logic txFinal
);
  localparam int IW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rst_n = rstSync_r[1];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [TMR_W-1:0] annInt_r;
  logic [TMR_W-1:0] repWait_r;
  logic [31:0] subId_r;
  logic [31:0] rdata_r;
  logic matched;
  logic matchedD_r;
  rwt_ann_t annState_r;
  rwt_rep_t repState_r;
  logic unsentAny, requestedAny, unackedAny;
  logic [IW:0] count_r;
  logic [SEQ_W-1:0] seqMin, seqMax_r;

  assign matched = ctrl_r[CTRL_MATCH_BIT];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      annInt_r <= TMR_W'(ANNOUNCE_CYCLES);
      repWait_r <= TMR_W'(REPAIR_CYC);
      subId_r <= SUBID_RST;
    end else if (regWrite) begin
      if (regAddr == REG_CTRL) begin
        ctrl_r <= regWdata[2:0];
      end else if (regAddr == REG_ANNOUNCE) begin
        annInt_r <= regWdata[TMR_W-1:0];
      end else if (regAddr == REG_REPAIR) begin
        repWait_r <= regWdata[TMR_W-1:0];
      end else if (regAddr == REG_SUBID) begin
        subId_r <= regWdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (regRead) begin
      if (regAddr == REG_CTRL) begin
        rdata_r <= {29'h0, ctrl_r};
      end else if (regAddr == REG_ANNOUNCE) begin
        rdata_r <= {8'h0, annInt_r};
      end else if (regAddr == REG_REPAIR) begin
        rdata_r <= {8'h0, repWait_r};
      end else if (regAddr == REG_STATUS) begin
        rdata_r <= 32'h0;
        rdata_r[STAT_ANN_POS +: 2] <= annState_r;
        rdata_r[STAT_REP_POS +: 2] <= repState_r;
        rdata_r[STAT_UNSENT_POS] <= unsentAny;
        rdata_r[STAT_REQ_POS] <= requestedAny;
        rdata_r[STAT_UNACK_POS] <= unackedAny;
        rdata_r[STAT_CNT_POS +: IW+1] <= count_r;
      end else if (regAddr == REG_SEQMIN) begin
        rdata_r <= seqMin;
      end else if (regAddr == REG_SEQMAX) begin
        rdata_r <= seqMax_r;
      end else if (regAddr == REG_SUBID) begin
        rdata_r <= subId_r;
      end else begin
        rdata_r <= 32'h0;
      end
    end
  end
  assign regRdata = rdata_r;

  // ---------------------------------------------------------------
  // change store with per-subscriber records
  // ---------------------------------------------------------------
  logic entValid [DEPTH];
  logic entRel [DEPTH];
  rwt_status_t entStat [DEPTH];
  logic [SEQ_W-1:0] entSeq [DEPTH];
  logic [IW-1:0] head_r, tail;
  logic addOk, retire, take, hbSend, canSend, useRep, usePush;
  logic [IW-1:0] selOff, pushOff, repOff;
  logic [IW:0] selRun;
  logic pushFound, repFound, selRel;
  logic [IW-1:0] selIdx;
  rwt_status_t selStat;
  logic hbPending_r;

  assign tail = head_r + count_r[IW-1:0];
  assign storeFull = (count_r == (IW+1)'(DEPTH));
  assign addOk = chgAdd && !storeFull && matched;
  // acknowledged oldest change leaves the store so the minimum advances
  assign retire = (count_r != '0) && (entStat[head_r] == ST_ACKED);
  assign seqMin = (count_r != '0) ? entSeq[head_r] : seqMax_r + 1'b1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= '0;
      count_r <= '0;
      seqMax_r <= '0;
    end else if (!matched) begin
      head_r <= '0;
      count_r <= '0;
    end else begin
      head_r <= head_r + IW'(retire);
      count_r <= count_r + (IW+1)'(addOk) - (IW+1)'(retire);
      if (addOk) begin
        seqMax_r <= chgAddSeq;
      end
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      logic [IW-1:0] off;
      logic [SEQ_W-1:0] diff;
      logic ackHit, reqHit, inTake;
      assign off = IW'(i) - head_r;
      assign diff = entSeq[i] - ackBase;
      assign ackHit = ackValid && entValid[i] && (entSeq[i] < ackBase);
      assign reqHit = ackValid && entValid[i] && (diff < SEQ_W'(DEPTH)) && ackBitmap[diff[IW-1:0]];
      assign inTake = take && entValid[i] && ((IW+1)'(off) >= (IW+1)'(selOff))
                      && ((IW+1)'(off) < (IW+1)'(selOff) + selRun);
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          entValid[i] <= 1'b0;
          entRel[i] <= 1'b0;
          entStat[i] <= ST_ACKED;
          entSeq[i] <= '0;
        end else if (!matched) begin
          entValid[i] <= 1'b0;
          entStat[i] <= ST_ACKED;
        end else if (addOk && IW'(i) == tail) begin
          entValid[i] <= 1'b1;
          entSeq[i] <= chgAddSeq;
          entRel[i] <= !chgAddReject;
          entStat[i] <= ctrl_r[CTRL_EAGER_BIT] ? ST_UNSENT : ST_UNACKED;
        end else if (retire && IW'(i) == head_r) begin
          entValid[i] <= 1'b0;
        end else if (entValid[i]) begin
          if (chgRemove && entSeq[i] == chgRemoveSeq) begin
            entRel[i] <= 1'b0;
          end
          // acknack-only states
          // a best-effort tracker sees no acknacks, so requested and acked stay unused
          // ack below base, request bitmap members
          if (ackHit) begin
            entStat[i] <= ST_ACKED;
          end else if (reqHit && entStat[i] != ST_UNDERWAY && entStat[i] != ST_ACKED) begin
            entStat[i] <= ST_REQUESTED;
          end else if (inTake) begin
            entStat[i] <= ST_UNDERWAY;
          // underway opens to new requests once the next heartbeat goes out
          end else if (hbSend && entStat[i] == ST_UNDERWAY) begin
            entStat[i] <= ST_UNACKED;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // change selection and gap merging
  // ---------------------------------------------------------------
  always_comb begin
    logic [IW-1:0] idx;
    logic runGo;
    idx = '0;
    runGo = 1'b0;
    pushFound = 1'b0;
    repFound = 1'b0;
    pushOff = '0;
    repOff = '0;
    unsentAny = 1'b0;
    requestedAny = 1'b0;
    unackedAny = 1'b0;
    for (int k = DEPTH - 1; k >= 0; k--) begin
      idx = head_r + IW'(k);
      if ((IW+1)'(k) < count_r) begin
        if (entStat[idx] == ST_UNSENT) begin
          pushFound = 1'b1;
          pushOff = IW'(k);
        end
        if (entStat[idx] == ST_REQUESTED) begin
          repFound = 1'b1;
          repOff = IW'(k);
        end
        if (entStat[idx] != ST_ACKED) begin
          unackedAny = 1'b1;
        end
      end
    end
    unsentAny = pushFound;
    requestedAny = repFound;
    useRep = (repState_r == REP_REPAIRING) && repFound;
    usePush = (annState_r == ANN_PUSHING) && pushFound && !useRep;
    selOff = useRep ? repOff : pushOff;
    selStat = useRep ? ST_REQUESTED : ST_UNSENT;
    selIdx = head_r + selOff;
    selRel = entRel[selIdx];
    // merge following irrelevant entries of the same kind
    selRun = '0;
    runGo = 1'b1;
    for (int k = 0; k < DEPTH; k++) begin
      idx = head_r + IW'(k);
      if (IW'(k) >= selOff && (IW+1)'(k) < count_r && runGo) begin
        if (entStat[idx] == selStat && !entRel[idx] && !selRel) begin
          selRun = selRun + 1'b1;
        end else begin
          runGo = 1'b0;
        end
      end
    end
    if (selRel) begin
      selRun = (IW+1)'(1);
    end
  end

  // ---------------------------------------------------------------
  // state sequences
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] hbCnt_r, repCnt_r;

  // both sequences start at match, end at unmatch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      matchedD_r <= 1'b0;
      annState_r <= ANN_IDLE;
    end else begin
      matchedD_r <= matched;
      if (!matched) begin
        annState_r <= ANN_IDLE;
      end else if (!matchedD_r) begin
        annState_r <= ANN_ANNOUNCING;
      end else begin
        case (annState_r)
          ANN_ANNOUNCING: begin
            if (unsentAny) begin
              annState_r <= ANN_PUSHING;
            end else if (!unackedAny) begin
              annState_r <= ANN_IDLE;
            end
          end
          ANN_PUSHING: begin
            if (!unsentAny) begin
              annState_r <= ANN_ANNOUNCING;
            end
          end
          default: begin
            if (unackedAny) begin
              annState_r <= ANN_ANNOUNCING;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      repState_r <= REP_WAITING;
      repCnt_r <= '0;
    end else if (!matched || !matchedD_r) begin
      repState_r <= REP_WAITING;
      repCnt_r <= '0;
    end else begin
      case (repState_r)
        REP_WAITING: begin
          if (requestedAny) begin
            repState_r <= REP_MUST;
            repCnt_r <= '0;
          end
        end
        REP_MUST: begin
          // acknacks keep updating, state held until the wait ends
          repCnt_r <= repCnt_r + 1'b1;
          if (repCnt_r + 1'b1 >= repWait_r) begin
            repState_r <= REP_REPAIRING;
          end
        end
        default: begin
          // no requests left returns to waiting
          if (!requestedAny) begin
            repState_r <= REP_WAITING;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hbCnt_r <= '0;
      hbPending_r <= 1'b0;
    end else if (!matched || annState_r != ANN_ANNOUNCING) begin
      hbCnt_r <= '0;
      hbPending_r <= 1'b0;
    end else if (hbCnt_r + 1'b1 >= annInt_r) begin
      hbCnt_r <= '0;
      hbPending_r <= 1'b1;
    end else begin
      hbCnt_r <= hbCnt_r + 1'b1;
      if (hbSend) begin
        hbPending_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // submessage output; a held slot stalls selection, nothing is queued
  // ---------------------------------------------------------------
  logic txValid_r, txInline_r;
  rwt_kind_t txKind_r;
  logic [SEQ_W-1:0] txSeq_r, txSeqLast_r;
  logic [31:0] txReaderId_r;

  assign canSend = !txValid_r || txReady;
  assign take = canSend && (useRep || usePush);
  assign hbSend = canSend && hbPending_r && !take && annState_r == ANN_ANNOUNCING;

  // one submessage per beat; framing into messages is downstream
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txValid_r <= 1'b0;
      txKind_r <= TX_DATA;
      txSeq_r <= '0;
      txSeqLast_r <= '0;
      txReaderId_r <= READER_UNKNOWN;
      txInline_r <= 1'b0;
    end else if (take) begin
      txValid_r <= 1'b1;
      txKind_r <= selRel ? TX_DATA : TX_GAP;
      txSeq_r <= entSeq[selIdx];
      txSeqLast_r <= entSeq[IW'(selIdx + selRun[IW-1:0] - 1'b1)];
      txReaderId_r <= useRep ? subId_r : READER_UNKNOWN;
      txInline_r <= selRel && ctrl_r[CTRL_INLINE_BIT];
    end else if (hbSend) begin
      txValid_r <= 1'b1;
      txKind_r <= TX_HEARTBEAT;
      txSeq_r <= seqMin;
      txSeqLast_r <= seqMax_r;
      txReaderId_r <= READER_UNKNOWN;
      txInline_r <= 1'b0;
    end else if (txReady) begin
      txValid_r <= 1'b0;
    end
  end

  assign txValid = txValid_r;
  assign txKind = txKind_r;
  assign txSeq = txSeq_r;
  assign txSeqLast = txSeqLast_r;
  assign txReaderId = txReaderId_r;
  assign txWriterId = WRITER_ID;
  assign txInline = txInline_r;
  // heartbeats never ask for a reply-free final
  assign txFinal = 1'b0;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // independent must-repair age
  // counted apart from the repair counter so the delay check does not restate its compare
  logic [TMR_W-1:0] mustAge_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mustAge_r <= '0;
    end else if (repState_r == REP_MUST) begin
      mustAge_r <= mustAge_r + 1'b1;
    end else begin
      mustAge_r <= '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_heartbeat_fields: assert property (hbSend |=> txValid && txKind == TX_HEARTBEAT
    && txReaderId == READER_UNKNOWN && txSeq == $past(seqMin) && !txFinal)
    else $error("heartbeat fields wrong");
  a_announce_to_push: assert property (annState_r == ANN_ANNOUNCING && matched && unsentAny
    && !regWrite |=> annState_r == ANN_PUSHING)
    else $error("announcing did not start pushing");
  a_push_to_announce: assert property (annState_r == ANN_PUSHING && matched && !unsentAny
    && !regWrite |=> annState_r == ANN_ANNOUNCING)
    else $error("pushing did not end");
  a_push_data_unknown: assert property (take && usePush && selRel
    |=> txKind == TX_DATA && txReaderId == READER_UNKNOWN)
    else $error("pushed data misaddressed");
  a_push_gap_kind: assert property (take && usePush && !selRel
    |=> txKind == TX_GAP && txReaderId == READER_UNKNOWN)
    else $error("irrelevant push not sent as gap");
  a_repair_addressed: assert property (take && useRep |=> txReaderId == $past(subId_r))
    else $error("repair not addressed to subscriber");
  a_repair_delay: assert property (repState_r == REP_MUST ##1 repState_r == REP_REPAIRING
    |-> mustAge_r >= $past(repWait_r))
    else $error("repairing entered early");
  a_repair_done: assert property (repState_r == REP_REPAIRING && matched && !requestedAny
    && !regWrite |=> repState_r == REP_WAITING)
    else $error("repairing did not end");
  a_unmatch_clear: assert property (!matched |=> count_r == '0 && annState_r == ANN_IDLE
    && repState_r == REP_WAITING)
    else $error("unmatch left state behind");

  c_heartbeat: cover property (hbSend);
  c_gap_merge: cover property (take && selRun > (IW+1)'(1));
  c_repair_sent: cover property (take && useRep);
  c_go_idle: cover property (annState_r == ANN_ANNOUNCING ##1 annState_r == ANN_IDLE);
endmodule // rwt_tracker

// *** hdl/rwt_pkg.sv ***
// constants and types of the reliable writer subscriber tracker
// Operation
// - announcing moves to pushing while unsent changes remain, no other action
// - pushing returns to announcing once nothing unsent; only attempted, not delivered
// - push takes next unsent, marks underway; relevant goes as DATA, unknown reader
// - irrelevant pushed change goes as GAP for its sequence, unknown reader
// - several DATA or GAP submessages may share one outgoing message
// - neighbouring irrelevant sequence numbers should merge into one GAP
// - announcing goes idle once every stored change is acknowledged
// - idle returns to announcing when any change is unacknowledged
// - heartbeat timer expiry sends HEARTBEAT with id, min, max, final clear
// - ACKNACK acknowledges all below base and requests bitmap members
// - waiting enters must-repair when any change is requested
// - ACKNACK in must-repair processed like waiting, state kept
// - repairing entered only after repair wait time from must-repair entry
// - repair takes next requested, marks underway, DATA to subscriber id
// - irrelevant repaired change goes as GAP to subscriber id
// - repairing returns to waiting once nothing requested
// - added change record is irrelevant if filter rejects, else relevant
// - added record starts unsent if eager send enabled, else unacknowledged
// - change removed by producer becomes irrelevant
// - unmatching discards the tracking entry from any state
// - each change keeps status and relevance, updated by protocol operation
// - best-effort variant uses only a subset of status states
// - resend requests for an underway change are ignored
package rwt_pkg;
  localparam int SEQ_W = 32;
  localparam int TMR_W = 24;
  // ---------------------------------------------------------------
  // register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ANNOUNCE = 4'h1;
  localparam logic [3:0] REG_REPAIR = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_SEQMIN = 4'h4;
  localparam logic [3:0] REG_SEQMAX = 4'h5;
  localparam logic [3:0] REG_SUBID = 4'h6;
  localparam int CTRL_MATCH_BIT = 0;
  localparam int CTRL_EAGER_BIT = 1;
  localparam int CTRL_INLINE_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [31:0] SUBID_RST = 32'h0000_0000;
  localparam logic [31:0] READER_UNKNOWN = 32'h0000_0000;
  localparam int STAT_ANN_POS = 0;
  localparam int STAT_REP_POS = 2;
  localparam int STAT_UNSENT_POS = 4;
  localparam int STAT_REQ_POS = 5;
  localparam int STAT_UNACK_POS = 6;
  localparam int STAT_CNT_POS = 8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int ANNOUNCE_TIME_US = 100;
  localparam int REPAIR_TIME_US = 200;
  localparam int ANNOUNCE_CYCLES = ANNOUNCE_TIME_US * CLK_MHZ;
  localparam int REPAIR_CYCLES = REPAIR_TIME_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_UNSENT, ST_REQUESTED, ST_UNDERWAY, ST_UNACKED, ST_ACKED} rwt_status_t;
  typedef enum logic [1:0] {ANN_IDLE, ANN_ANNOUNCING, ANN_PUSHING} rwt_ann_t;
  typedef enum logic [1:0] {REP_WAITING, REP_MUST, REP_REPAIRING} rwt_rep_t;
  typedef enum logic [1:0] {TX_DATA, TX_GAP, TX_HEARTBEAT} rwt_kind_t;
endpackage

// *** tb/rwt_reader_model.sv ***
// remote reader model: accepts submessages and logs them in order
module rwt_reader_model import rwt_pkg::*; (
  input wire logic mclk,
  input wire logic slow,
  input wire logic txValid,
  output logic txReady,
  input wire rwt_kind_t txKind,
  input wire logic [SEQ_W-1:0] txSeq,
  input wire logic [SEQ_W-1:0] txSeqLast,
  input wire logic [31:0] txReaderId,
  input wire logic txInline,
  input wire logic txFinal
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div = 2'h0;
  logic [98:0] txLog [16];
  int n = 0;
  logic finSeen = 1'b0;
  // slow mode takes one submessage in four cycles so the slot has to hold
  assign txReady = slow ? (div == 2'h3) : 1'b1;
  always @(posedge mclk) begin
    div <= div + 2'h1;
    if (txValid && txReady) begin
      txLog[n % 16] <= {txKind, txInline, txSeq, txSeqLast, txReaderId};
      n <= n + 1;
      if (txFinal) begin
        finSeen <= 1'b1;
      end
    end
  end
endmodule // rwt_reader_model

// *** tb/reliable_writer_reader_tracker_tb_top.sv ***
// self-checking bench of the subscriber tracker
module reliable_writer_reader_tracker_tb_top import rwt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary writer identifier
  localparam logic [31:0] WID = 32'h0000_0C3D;
  localparam logic [31:0] SID = 32'h0000_0B07;
  localparam int RCYC = 20;
  logic mclk, arst_n, regWrite, regRead, chgAdd, chgAddReject, storeFull;
  logic chgRemove, ackValid, txValid, txReady, txInline, txFinal, slow;
  logic [3:0] regAddr;
  logic [7:0] ackBitmap;
  logic [31:0] regWdata, regRdata, chgAddSeq, chgRemoveSeq, ackBase;
  logic [31:0] txSeq, txSeqLast, txReaderId, txWriterId, rv;
  rwt_kind_t txKind;
  int num_errors = 0;
  int total_checks = 0;
  int nx = 0;
  logic inl = 1'b1;
  rwt_tracker #(.DEPTH(8), .REPAIR_CYC(RCYC), .WRITER_ID(WID)) uut (.mclk(mclk),
    .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .chgAdd(chgAdd), .chgAddSeq(chgAddSeq),
    .chgAddReject(chgAddReject), .storeFull(storeFull), .chgRemove(chgRemove),
    .chgRemoveSeq(chgRemoveSeq), .ackValid(ackValid), .ackBase(ackBase),
    .ackBitmap(ackBitmap), .txValid(txValid), .txReady(txReady), .txKind(txKind),
    .txSeq(txSeq), .txSeqLast(txSeqLast), .txReaderId(txReaderId),
    .txWriterId(txWriterId), .txInline(txInline), .txFinal(txFinal));
  rwt_reader_model mdl (.mclk(mclk), .slow(slow), .txValid(txValid), .txReady(txReady),
    .txKind(txKind), .txSeq(txSeq), .txSeqLast(txSeqLast), .txReaderId(txReaderId),
    .txInline(txInline), .txFinal(txFinal));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rv = regRdata;
  endtask
  task automatic st(input logic [6:0] e);
    repeat (3) @(posedge mclk);
    rd(REG_STATUS);
    chk("status", 32'(rv[6:0]), 32'(e));
  endtask
  task automatic add(input logic [31:0] s, input logic rej);
    @(posedge mclk);
    chgAdd <= 1'b1;
    chgAddSeq <= s;
    chgAddReject <= rej;
    @(posedge mclk);
    chgAdd <= 1'b0;
    chgAddSeq <= ~s;
  endtask
  task automatic ack(input logic [31:0] b, input logic [7:0] m);
    @(posedge mclk);
    ackValid <= 1'b1;
    ackBase <= b;
    ackBitmap <= m;
    @(posedge mclk);
    ackValid <= 1'b0;
    ackBase <= ~b;
    ackBitmap <= ~m;
  endtask
  // next logged submessage against the expected one; a long silence ends the run
  task automatic chkTx(input logic [1:0] k, input logic [31:0] s, input logic [31:0] l,
      input logic [31:0] r);
    int i;
    logic [98:0] e;
    for (i = 0; i < 400 && mdl.n <= nx; i++) @(posedge mclk);
    if (mdl.n <= nx) begin
      num_errors++;
      results();
    end
    e = mdl.txLog[nx];
    nx++;
    chk("txKind", 32'(e[98:97]), 32'(k));
    chk("txSeq", e[95:64], s);
    chk("txSeqLast", e[63:32], l);
    chk("txReaderId", e[31:0], r);
    chk("txInline", 32'(e[96]), 32'(k == TX_DATA && inl));
  endtask
  initial begin
    arst_n = 1'b0;
    {regWrite, regRead, chgAdd, chgAddReject, chgRemove, ackValid} = 6'h00;
    regAddr = 4'h0;
    {regWdata, chgAddSeq, chgRemoveSeq, ackBase} = 128'h0;
    ackBitmap = 8'h00;
    slow = 1'b1;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(REG_CTRL);
    chk("ctrl", rv, 32'(CTRL_RST));
    rd(4'hF);
    chk("unmapped", rv, 32'h0);
    wr(REG_REPAIR, RCYC);
    wr(REG_SUBID, SID);
    wr(REG_ANNOUNCE, 32'h00FF_FFFF);
    wr(REG_CTRL, 32'h0000_0007);
    st(7'h00);
    add(32'h1, 1'b0);
    add(32'h2, 1'b1);
    add(32'h3, 1'b1);
    chkTx(TX_DATA, 32'h1, 32'h1, READER_UNKNOWN);
    chkTx(TX_GAP, 32'h2, 32'h3, READER_UNKNOWN);
    st(7'h41);
    slow <= 1'b0;
    wr(REG_ANNOUNCE, 32'h0000_0020);
    chkTx(TX_HEARTBEAT, 32'h1, 32'h3, READER_UNKNOWN);
    chk("txWriterId", txWriterId, WID);
    chk("txFinal", 32'(mdl.finSeen), 32'h0);
    wr(REG_ANNOUNCE, 32'h00FF_FFFF);
    ack(32'h1, 8'h01);
    st(7'h65);
    ack(32'h1, 8'h06);
    st(7'h65);
    chk("txCount", mdl.n, nx);
    chkTx(TX_DATA, 32'h1, 32'h1, SID);
    chkTx(TX_GAP, 32'h2, 32'h3, SID);
    ack(32'h1, 8'h01);
    st(7'h41);
    ack(32'h4, 8'h00);
    st(7'h00);
    wr(REG_CTRL, 32'h0000_0005);
    add(32'h4, 1'b0);
    st(7'h41);
    @(posedge mclk);
    chgRemove <= 1'b1;
    chgRemoveSeq <= 32'h4;
    @(posedge mclk);
    chgRemove <= 1'b0;
    chgRemoveSeq <= 32'hFFFF_FFFB;
    ack(32'h4, 8'h01);
    chkTx(TX_GAP, 32'h4, 32'h4, SID);
    wr(REG_CTRL, 32'h0000_0003);
    inl = 1'b0;
    for (int s = 5; s < 13; s++) add(32'(s), 1'b0);
    #1 chk("storeFull", 32'(storeFull), 32'h1);
    chkTx(TX_DATA, 32'h5, 32'h5, READER_UNKNOWN);
    rd(REG_STATUS);
    chk("count", 32'(rv[11:8]), 32'h8);
    wr(REG_CTRL, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    rd(REG_STATUS);
    chk("status", rv, 32'h0);
    results();
  end
endmodule // reliable_writer_reader_tracker_tb_top
